// ### acs_pkg.sv
// constants for the converter sequencing block
// assumes a single peripheral bus clock drives everything
package acs_pkg;
    localparam logic [1:0] MODE_SW_NOWAIT = 2'h0;
    localparam logic [1:0] MODE_SW_WAIT   = 2'h1;
    localparam logic [1:0] MODE_HW_NOWAIT = 2'h2;
    localparam logic [1:0] MODE_HW_WAIT   = 2'h3;
    localparam logic [2:0] DIV_MAX_SEL    = 3'h5;
    localparam int         DIV_W          = 5;
    localparam int         CNT_W          = 10;
    localparam logic [9:0] SEL_CONV_NM1   = 10'h040;
    localparam logic [9:0] SEL_CONV_NM2   = 10'h0B5;
    localparam logic [9:0] SEL_CONV_LV1   = 10'h050;
    localparam logic [9:0] SEL_CONV_LV2   = 10'h06B;
    localparam logic [9:0] SCAN_CONV_NM1  = 10'h100;
    localparam logic [9:0] SCAN_CONV_NM2  = 10'h2D4;
    localparam logic [9:0] SCAN_CONV_LV1  = 10'h140;
    localparam logic [9:0] SCAN_CONV_LV2  = 10'h1AC;
    localparam logic [9:0] NOWAIT_START_DLY = 10'h001;
    localparam logic [9:0] NOWAIT_IRQ_DLY   = 10'h001;
    localparam logic [9:0] WAIT_IRQ_DLY     = 10'h004;
    localparam logic [9:0] SEQ_IRQ_SHORTEN  = 10'h003;
    localparam logic [9:0] STAB_SLOW        = 10'h004;
    localparam logic [9:0] STAB_MID         = 10'h006;
    localparam logic [9:0] STAB_FAST_0      = 10'h00A;
    localparam logic [9:0] STAB_FAST_1      = 10'h012;
    localparam logic [9:0] STAB_FAST_2      = 10'h022;
    localparam logic [4:0] WAIT_START_PCLK  = 5'h01;
    typedef enum logic [2:0] {
        ACS_IDLE  = 3'b000,
        ACS_START = 3'b001,
        ACS_DLY   = 3'b010,
        ACS_STAB  = 3'b011,
        ACS_CONV  = 3'b100,
        ACS_IRQ   = 3'b101
    } acs_state_t;
    typedef enum logic [1:0] {
        ACS_OP_STOPPED  = 2'b00,
        ACS_OP_TRG_STBY = 2'b01,
        ACS_OP_CNV_STBY = 2'b10,
        ACS_OP_CONVERT  = 2'b11
    } acs_op_t;
endpackage

// ### acs_clkdiv.sv
// conversion clock tick generator and start-time lookup
// assumes divider select is stable while converting
`timescale 1ns/1ns
module acs_clkdiv (
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       sync_in,
    input  wire logic [2:0] clock_divider_sel_in,
    output logic            tick_out,
    output logic [4:0]      start_pclk_out
);
    logic [4:0] cnt_r;
    logic [4:0] term;

    always_comb begin
        unique case (clock_divider_sel_in)
            3'h0: term = 5'h1F;
            3'h1: term = 5'h0F;
            3'h2: term = 5'h07;
            3'h3: term = 5'h03;
            3'h4: term = 5'h01;
            default: term = 5'h00;
        endcase
    end

    // divide by term+1; sync realigns the phase to each start
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || sync_in) begin
            cnt_r    <= 5'h00;
            tick_out <= 1'b0;
        end else if (cnt_r >= term) begin
            cnt_r    <= 5'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 5'h01;
            tick_out <= 1'b0;
        end
    end

    // no-wait start time in bus clocks; ties to the divider
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            start_pclk_out <= 5'h01;
        end else if (term == 5'h00) begin
            start_pclk_out <= 5'h01;
        end else begin
            start_pclk_out <= term;
        end
    end
endmodule

// ### acs_seq.sv
// sequencing of one conversion: start time, stabilisation, conversion, irq delay
// assumes software obeys the run/enable write restrictions; all ports synchronous
`timescale 1ns/1ns
module acs_seq (
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       run_set_in,
    input  wire logic       run_clr_in,
    input  wire logic       comparator_enable_bit_in,
    input  wire logic [1:0] trig_mode_in,
    input  wire logic       hw_trigger_in,
    input  wire logic       select_scan_sel_in,
    input  wire logic       sequential_in,
    input  wire logic [2:0] clock_divider_sel_in,
    input  wire logic [1:0] voltage_mode_sel_in,
    input  wire logic       low_power_sel_in,
    output logic            conv_run_bit_out,
    output logic [1:0]      op_state_out,
    output logic            converting_out,
    output logic            conv_done_irq_out
);
    acs_pkg::acs_state_t st_r;
    logic [9:0]          cnt_r;
    logic [4:0]          pcnt_r;
    logic                repeat_r;
    logic                run_r;
    logic                tick;
    logic [4:0]          start_pclk;
    logic                div_sync;
    logic                is_wait;
    logic                is_hw;
    logic [9:0]          conv_len;
    logic [9:0]          stab_len;
    logic [9:0]          irq_len;
    logic                begin_conv;

    assign is_wait  = trig_mode_in[0];
    assign is_hw    = trig_mode_in[1];
    // divider held through the start time, so the clock-tick delays follow it
    assign div_sync = (st_r == acs_pkg::ACS_IDLE) || (st_r == acs_pkg::ACS_START);

    acs_clkdiv u_div (
        .clk_sys_in           (clk_sys_in),
        .resetn_in            (resetn_in),
        .sync_in              (div_sync),
        .clock_divider_sel_in (clock_divider_sel_in),
        .tick_out             (tick),
        .start_pclk_out       (start_pclk)
    );

    always_comb begin
        unique case ({select_scan_sel_in, voltage_mode_sel_in})
            3'b000: conv_len = acs_pkg::SEL_CONV_NM1;
            3'b001: conv_len = acs_pkg::SEL_CONV_NM2;
            3'b010: conv_len = acs_pkg::SEL_CONV_LV1;
            3'b011: conv_len = acs_pkg::SEL_CONV_LV2;
            3'b100: conv_len = acs_pkg::SCAN_CONV_NM1;
            3'b101: conv_len = acs_pkg::SCAN_CONV_NM2;
            3'b110: conv_len = acs_pkg::SCAN_CONV_LV1;
            default: conv_len = acs_pkg::SCAN_CONV_LV2;
        endcase
    end

    // stabilisation wait in conversion clocks
    always_comb begin
        if (!low_power_sel_in && clock_divider_sel_in == 3'h2) begin
            stab_len = acs_pkg::STAB_MID;
        end else if (!low_power_sel_in && clock_divider_sel_in < 3'h2) begin
            stab_len = acs_pkg::STAB_SLOW;
        end else if (clock_divider_sel_in == 3'h3) begin
            stab_len = low_power_sel_in ? acs_pkg::STAB_SLOW : acs_pkg::STAB_FAST_0;
        end else if (clock_divider_sel_in == 3'h4) begin
            stab_len = low_power_sel_in ? acs_pkg::STAB_SLOW : acs_pkg::STAB_FAST_1;
        end else begin
            stab_len = low_power_sel_in ? acs_pkg::STAB_MID : acs_pkg::STAB_FAST_2;
        end
    end

    // irq delay: 1 no-wait, 4 wait one-shot, 1 wait sequential
    always_comb begin
        if (!is_wait) begin
            irq_len = acs_pkg::NOWAIT_IRQ_DLY;
        end else if (sequential_in) begin
            irq_len = acs_pkg::WAIT_IRQ_DLY - acs_pkg::SEQ_IRQ_SHORTEN;
        end else begin
            irq_len = acs_pkg::WAIT_IRQ_DLY;
        end
    end

    // hw modes need enable set and a trigger; sw wait starts on run, sw no-wait on run with enable set
    always_comb begin
        if (is_hw) begin
            begin_conv = comparator_enable_bit_in && hw_trigger_in
                         && (is_wait || run_r);
        end else if (is_wait) begin
            begin_conv = run_r;
        end else begin
            begin_conv = run_r && comparator_enable_bit_in;
        end
    end

    // main sequencer; run_clr aborts any conversion in flight
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            st_r     <= acs_pkg::ACS_IDLE;
            cnt_r    <= 10'h000;
            pcnt_r   <= 5'h00;
            repeat_r <= 1'b0;
        end else if (run_clr_in) begin
            st_r     <= acs_pkg::ACS_IDLE;
            repeat_r <= 1'b0;
        end else begin
            unique case (st_r)
                acs_pkg::ACS_IDLE: begin
                    if (begin_conv) begin
                        if (is_hw && repeat_r) begin
                            // repeated hw starts skip start and stab
                            st_r  <= acs_pkg::ACS_CONV;
                            cnt_r <= conv_len;
                        end else begin
                            st_r   <= acs_pkg::ACS_START;
                            // wait modes: one bus clock
                            pcnt_r <= is_wait ? acs_pkg::WAIT_START_PCLK : start_pclk;
                        end
                    end
                end
                acs_pkg::ACS_START: begin
                    if (pcnt_r <= 5'h01) begin
                        st_r  <= is_wait ? acs_pkg::ACS_STAB : acs_pkg::ACS_DLY;
                        cnt_r <= is_wait ? stab_len : acs_pkg::NOWAIT_START_DLY;
                    end else begin
                        pcnt_r <= pcnt_r - 5'h01;
                    end
                end
                acs_pkg::ACS_DLY, acs_pkg::ACS_STAB: begin
                    if (tick) begin
                        if (cnt_r <= 10'h001) begin
                            st_r  <= acs_pkg::ACS_CONV;
                            cnt_r <= conv_len;
                        end else begin
                            cnt_r <= cnt_r - 10'h001;
                        end
                    end
                end
                acs_pkg::ACS_CONV: begin
                    if (tick) begin
                        if (cnt_r <= 10'h001) begin
                            st_r  <= acs_pkg::ACS_IRQ;
                            cnt_r <= irq_len;
                        end else begin
                            cnt_r <= cnt_r - 10'h001;
                        end
                    end
                end
                acs_pkg::ACS_IRQ: begin
                    if (tick && cnt_r <= 10'h001) begin
                        st_r     <= acs_pkg::ACS_IDLE;
                        repeat_r <= sequential_in;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 10'h001;
                    end
                end
                default: st_r <= acs_pkg::ACS_IDLE;
            endcase
        end
    end

    // run bit: set/clear by software, set by hw wait trigger, auto-clear
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            run_r <= 1'b0;
        end else if (run_clr_in) begin
            run_r <= 1'b0;
        end else if (is_hw && is_wait && hw_trigger_in && comparator_enable_bit_in) begin
            run_r <= 1'b1;
        end else if (run_set_in && !(is_hw && is_wait)) begin
            run_r <= 1'b1; // software set ignored in hw wait
        end else if (st_r == acs_pkg::ACS_IRQ && tick && cnt_r <= 10'h001
                     && !sequential_in && !(is_hw && !is_wait)) begin
            run_r <= 1'b0;
        end
    end

    // pulse on completion of each conversion or four-channel scan
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            conv_done_irq_out <= 1'b0;
        end else begin
            conv_done_irq_out <= !run_clr_in && st_r == acs_pkg::ACS_IRQ
                                 && tick && cnt_r <= 10'h001;
        end
    end

    // operating state derived from run, enable, trigger mode and sequencer state
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            op_state_out     <= acs_pkg::ACS_OP_STOPPED;
            conv_run_bit_out <= 1'b0;
            converting_out   <= 1'b0;
        end else begin
            conv_run_bit_out <= run_r;
            converting_out   <= (st_r != acs_pkg::ACS_IDLE);
            unique case ({run_r, comparator_enable_bit_in})
                2'b00: op_state_out <= acs_pkg::ACS_OP_STOPPED;
                2'b01: op_state_out <= (is_hw && is_wait) ? acs_pkg::ACS_OP_TRG_STBY
                                                          : acs_pkg::ACS_OP_CNV_STBY;
                2'b10: op_state_out <= (!is_hw && is_wait) ? acs_pkg::ACS_OP_CONVERT
                                                           : acs_pkg::ACS_OP_STOPPED;
                default: op_state_out <= (is_hw && !is_wait && st_r == acs_pkg::ACS_IDLE)
                                         ? acs_pkg::ACS_OP_TRG_STBY
                                         : acs_pkg::ACS_OP_CONVERT;
            endcase
        end
    end
endmodule

// ### acs_trig_src.sv
// hardware trigger source model facing the sequencer
// assumes requests on fire_in are driven at the falling edge
`timescale 1ns/1ns
module acs_trig_src (
    input  wire logic        clk_in,
    input  wire logic        fire_in,
    input  wire logic [11:0] gap_in,
    output logic             hw_trigger_out
);
    logic [11:0] since_r;
    logic        fire_r;
    logic        ok;
    assign ok = fire_r && (since_r >= gap_in);
    initial begin
        hw_trigger_out = 1'b0;
        since_r = 12'hFFF;
        fire_r = 1'b0;
    end
    // request taken at the rising edge, away from the falling-edge stimulus
    always @(posedge clk_in) begin
        fire_r <= fire_in;
    end
    // early requests are dropped, not queued, as a real source would lose them
    always @(negedge clk_in) begin
        hw_trigger_out <= ok;
        since_r <= ok ? 12'h000 : since_r + {11'h000, since_r != 12'hFFF};
    end
endmodule

// ### acs_seq_asserts.sv
// port checker for the conversion sequencer
// assumes it is bound to acs_seq; one clock domain
`timescale 1ns/1ns
module acs_seq_asserts (
    input wire logic       clk_sys_in,
    input wire logic       resetn_in,
    input wire logic       run_set_in,
    input wire logic       run_clr_in,
    input wire logic       comparator_enable_bit_in,
    input wire logic [1:0] trig_mode_in,
    input wire logic       hw_trigger_in,
    input wire logic       sequential_in,
    input wire logic       conv_run_bit_out,
    input wire logic [1:0] op_state_out,
    input wire logic       converting_out,
    input wire logic       conv_done_irq_out
);
    logic [11:0] busy_r;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // saturates so a long slow-divider conversion cannot wrap below the floor
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !converting_out) busy_r <= 12'h000;
        else if (busy_r != 12'hFFF) busy_r <= busy_r + 12'h001;
    end
    a_irq_one_cycle: assert property (conv_done_irq_out |=> !conv_done_irq_out)
        else $error("irq longer than one cycle");
    a_irq_min_time: assert property (conv_done_irq_out |-> busy_r >= 12'h03C)
        else $error("irq before a full conversion");
    a_irq_from_conv: assert property (conv_done_irq_out |-> $past(converting_out))
        else $error("irq while idle");
    a_clr_run_low: assert property (run_clr_in ##1 !(run_set_in || hw_trigger_in)
        |=> !conv_run_bit_out) else $error("run bit kept after clear");
    a_clr_no_irq: assert property (run_clr_in |=> ##1 !conv_done_irq_out [*4])
        else $error("irq after abort");
    a_hw_wait_run: assert property ((trig_mode_in == acs_pkg::MODE_HW_WAIT &&
        comparator_enable_bit_in && hw_trigger_in && !converting_out && !run_clr_in)
        ##1 !run_clr_in |=> conv_run_bit_out) else $error("trigger did not set run");
    a_oneshot_clear: assert property (conv_done_irq_out && !sequential_in &&
        trig_mode_in != acs_pkg::MODE_HW_NOWAIT && !run_set_in && !hw_trigger_in
        |=> !conv_run_bit_out) else $error("run bit not cleared");
    a_hw_keep_run: assert property (conv_done_irq_out && !run_clr_in &&
        trig_mode_in == acs_pkg::MODE_HW_NOWAIT |=> conv_run_bit_out)
        else $error("run bit dropped");
    a_op_stopped: assert property ((!comparator_enable_bit_in && !conv_run_bit_out) [*3]
        |-> op_state_out == acs_pkg::ACS_OP_STOPPED) else $error("state not stopped");
    a_op_standby: assert property ((comparator_enable_bit_in && !conv_run_bit_out &&
        $stable(trig_mode_in)) [*3] |-> op_state_out == ((trig_mode_in == acs_pkg::MODE_HW_WAIT)
        ? acs_pkg::ACS_OP_TRG_STBY : acs_pkg::ACS_OP_CNV_STBY)) else $error("bad standby");
    c_seq_irq: cover property (conv_done_irq_out && sequential_in);
    c_hw_irq: cover property (conv_done_irq_out && trig_mode_in == acs_pkg::MODE_HW_NOWAIT);
    c_trg_stby: cover property (op_state_out == acs_pkg::ACS_OP_TRG_STBY);
endmodule
bind acs_seq acs_seq_asserts u_acs_seq_asserts (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .run_set_in(run_set_in), .run_clr_in(run_clr_in),
    .comparator_enable_bit_in(comparator_enable_bit_in), .trig_mode_in(trig_mode_in),
    .hw_trigger_in(hw_trigger_in), .sequential_in(sequential_in),
    .conv_run_bit_out(conv_run_bit_out), .op_state_out(op_state_out),
    .converting_out(converting_out), .conv_done_irq_out(conv_done_irq_out));

// ### tb_top.sv
// self-checking bench for the conversion sequencer
// assumes acs_seq as top with the trigger source model beside it
`timescale 1ns/1ns
module tb_top;
    logic       clk, rstn, set, clr, en, fire, scan, seq, lp, trg, run, busy, irq;
    logic [1:0] mode, lv, op;
    logic [2:0] div;
    int         bad_count, tests_run;
    int sel_t[4] = '{64, 181, 80, 107};
    int scn_t[4] = '{256, 724, 320, 428};
    int dv_t[6] = '{32, 16, 8, 4, 2, 1};
    int st_t[6] = '{31, 15, 7, 3, 1, 1};
    int stb_t[3] = '{4, 4, 6};
    acs_seq u_acs_seq (.clk_sys_in(clk), .resetn_in(rstn), .run_set_in(set), .run_clr_in(clr),
        .comparator_enable_bit_in(en), .trig_mode_in(mode), .hw_trigger_in(trg),
        .select_scan_sel_in(scan), .sequential_in(seq), .clock_divider_sel_in(div),
        .voltage_mode_sel_in(lv), .low_power_sel_in(lp), .conv_run_bit_out(run),
        .op_state_out(op), .converting_out(busy), .conv_done_irq_out(irq));
    acs_trig_src u_acs_trig_src (.clk_in(clk), .fire_in(fire), .gap_in(12'h0CA),
        .hw_trigger_out(trg));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #1200000;
        bad_count++;
        end_sim();
    end
    task automatic end_sim();
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    // pipeline slack of a few cycles is accepted, the divided counts are not
    task automatic chk_lat(input int exp, input int got);
        tests_run++;
        if (got < exp || got > exp + 5) begin
            bad_count++;
            $display("mismatch latency exp %0d got %0d", exp, got);
        end
    endtask
    task automatic cfg(input logic [1:0] m, input logic sc, input logic sq, input logic [2:0] d,
                       input logic [1:0] v, input logic p);
        @(negedge clk);
        mode = m;
        scan = sc;
        seq = sq;
        div = d;
        lv = v;
        lp = p;
    endtask
    // 0 run set, 1 trigger, 2 run clear; triggers keep the source spacing
    task automatic go(input int k);
        if (k == 1) repeat (210) @(negedge clk);
        @(negedge clk);
        set = (k == 0);
        fire = (k == 1);
        clr = (k == 2);
        @(negedge clk);
        set = 1'b0;
        fire = 1'b0;
        clr = 1'b0;
    endtask
    task automatic meas(input int exp);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < exp + 60) begin
            @(negedge clk);
            n++;
        end
        chk_lat(exp, n);
        @(negedge clk);
    endtask
    initial begin
        {set, clr, en, fire, scan, seq, lp, rstn} = 8'h00;
        mode = 2'h0;
        lv = 2'h0;
        div = 3'h5;
        bad_count = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk_val("op state", acs_pkg::ACS_OP_STOPPED, op);
        en = 1'b1;
        for (int v = 0; v < 4; v++) begin
            cfg(acs_pkg::MODE_SW_NOWAIT, 1'b0, 1'b0, 3'h5, v[1:0], 1'b0);
            go(0);
            meas(3 + sel_t[v]);
            chk_val("run bit", 2'h0, {1'b0, run});
            cfg(acs_pkg::MODE_SW_NOWAIT, 1'b1, 1'b0, 3'h5, v[1:0], 1'b0);
            go(0);
            meas(3 + scn_t[v]);
        end
        for (int d = 0; d < 5; d++) begin
            cfg(acs_pkg::MODE_SW_NOWAIT, 1'b0, 1'b0, d[2:0], 2'h0, 1'b0);
            go(0);
            meas(st_t[d] + dv_t[d] * 66);
        end
        for (int d = 0; d < 3; d++) begin
            cfg(acs_pkg::MODE_SW_WAIT, 1'b0, 1'b0, d[2:0], 2'h0, 1'b0);
            go(0);
            meas(1 + dv_t[d] * (stb_t[d] + 68));
        end
        cfg(acs_pkg::MODE_HW_NOWAIT, 1'b0, 1'b0, 3'h5, 2'h0, 1'b0);
        go(0);
        repeat (2) begin
            go(1);
            meas(68);
            chk_val("run bit", 2'h1, {1'b0, run});
        end
        go(2);
        cfg(acs_pkg::MODE_HW_WAIT, 1'b0, 1'b0, 3'h5, 2'h0, 1'b1);
        repeat (4) @(negedge clk);
        chk_val("op state", acs_pkg::ACS_OP_TRG_STBY, op);
        go(1);
        repeat (3) @(negedge clk);
        chk_val("run bit", 2'h1, {1'b0, run});
        meas(73);
        chk_val("run bit", 2'h0, {1'b0, run});
        cfg(acs_pkg::MODE_HW_WAIT, 1'b0, 1'b1, 3'h5, 2'h0, 1'b1);
        go(1);
        meas(73);
        go(1);
        meas(65);
        repeat (20) @(negedge clk);
        chk_val("op state", acs_pkg::ACS_OP_CONVERT, op);
        go(2);
        repeat (3) @(negedge clk);
        chk_val("op state", acs_pkg::ACS_OP_TRG_STBY, op);
        repeat (100) @(negedge clk);
        end_sim();
    end
endmodule
